// *** logic/bbox_pkg.sv ***
package bbox_pkg;
   // ---------------------------------------------
   // Record layout
   // ---------------------------------------------
   localparam int REC_BYTES = 38;
   localparam int SLOTS = 5;
   localparam int BYTE_W = 8;
   localparam int TIME_W = 24;
   localparam int RTC_W = 32;
   localparam int CYC_W = 16;
   localparam int STATUS_WORD_W = 16;
   localparam int STATUS_W = 8;
   localparam int READING_W = 16;
   localparam int EVT_CNT_W = 40;
   localparam int SLOT_IDX_W = 3;
   localparam int BYTE_IDX_W = 6;
   localparam int CFG_W = 8;
   // ---------------------------------------------
   // Reset values and limits
   // ---------------------------------------------
   localparam logic [CFG_W-1:0] CONFIG_RESET = 8'h01;
   localparam logic [CFG_W-1:0] CONFIG_MASK = 8'h01;
   localparam int ENABLE_BIT = 0;
   localparam logic [CYC_W-1:0] CYC_MAX = 16'hFFFF;
   localparam logic [TIME_W-1:0] TIME_MAX = 24'hFFFFFF;
   localparam logic [BYTE_W-1:0] EMPTY_BYTE = 8'h00;
   // ---------------------------------------------
   // Timing
   // ---------------------------------------------
   localparam longint unsigned CLK_HZ = 100_000_000;
   localparam longint unsigned MINUTE_S = 60;
   localparam longint unsigned MINUTE_CYCLES = MINUTE_S * CLK_HZ;
   localparam int PRE_W = 40;
   // ---------------------------------------------
   // Types
   // ---------------------------------------------
   // Declared last field first so the lowest byte is the first one stored
   typedef struct packed {
      logic [EVT_CNT_W-1:0] event_counts;
      logic [READING_W-1:0] read_vout;
      logic [READING_W-1:0] read_pin;
      logic [READING_W-1:0] read_fan_speed;
      logic [READING_W-1:0] read_temp2;
      logic [READING_W-1:0] read_temp1;
      logic [READING_W-1:0] read_iout;
      logic [READING_W-1:0] read_iin;
      logic [READING_W-1:0] read_vin;
      logic [STATUS_W-1:0] status_fan;
      logic [STATUS_W-1:0] status_temp;
      logic [STATUS_W-1:0] status_input;
      logic [STATUS_W-1:0] status_iout;
      logic [STATUS_WORD_W-1:0] status_word;
   } telemetry_t;

   typedef struct packed {
      logic [CYC_W-1:0] request_cycles;
      logic [CYC_W-1:0] ac_cycles;
   } cycle_counts_t;

   typedef logic [REC_BYTES-1:0][BYTE_W-1:0] record_t;

   function automatic logic [CYC_W-1:0] sat_inc(input logic [CYC_W-1:0] v);
      sat_inc = (v == CYC_MAX) ? v : v + 16'h0001;
   endfunction : sat_inc
endpackage : bbox_pkg

// *** logic/power_cycle_tracker.sv ***
`timescale 1ns/1ps
`default_nettype none
module power_cycle_tracker import bbox_pkg::*; (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic mains_ok,
   input wire logic power_request,
   output cycle_counts_t counts
);
   // ---------------------------------------------
   // Off/on cycle counting
   // ---------------------------------------------
   logic prev_on;
   logic cause_ac;
   logic next_cause_ac;
   cycle_counts_t next_counts;
   logic on_now;
   // The turn-on after reset has no turn-off before it, so it is no cycle
   logic seen_on;
   logic next_seen_on;

   assign on_now = mains_ok && power_request;

   always_comb begin
      next_counts = counts;
      next_cause_ac = cause_ac;
      next_seen_on = seen_on || on_now;
      if (prev_on && !on_now) begin
         // Both dropping together is charged to the mains
         next_cause_ac = !mains_ok;
      end
      if (!prev_on && on_now && seen_on) begin
         if (cause_ac) begin
            next_counts.ac_cycles = sat_inc(counts.ac_cycles);
         end else begin
            next_counts.request_cycles = sat_inc(counts.request_cycles);
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         prev_on <= 1'b0;
         cause_ac <= 1'b1;
         seen_on <= 1'b0;
         counts <= '0;
      end else begin
         prev_on <= on_now;
         seen_on <= next_seen_on;
         cause_ac <= next_cause_ac;
         counts <= next_counts;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   sequence ac_return;
      !prev_on && on_now && seen_on && cause_ac && counts.ac_cycles != CYC_MAX;
   endsequence
   sequence request_return;
      !prev_on && on_now && seen_on && !cause_ac && counts.request_cycles != CYC_MAX;
   endsequence
   sequence first_turn_on;
      !prev_on && on_now && !seen_on;
   endsequence

   a_ac_cycle_count: assert property (ac_return |=> counts.ac_cycles == $past(counts.ac_cycles) + 16'h0001)
      else $error("mains cycle count did not advance");
   a_request_cycle_count: assert property (request_return
      |=> counts.request_cycles == $past(counts.request_cycles) + 16'h0001 && $stable(counts.ac_cycles))
      else $error("request cycle count did not advance");
   a_first_on_free: assert property (first_turn_on |=> $stable(counts))
      else $error("first turn-on after reset was counted");
endmodule : power_cycle_tracker
`default_nettype wire

// *** logic/black_box_event_record.sv ***
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Newest slot holds latest event's 38-byte record
// - Cycle counters run always, minutes only while powered; copied at each event
// - Power-on minutes, three bytes, one-minute step
// - Host clock value stored, four bytes, not generated
// - Count mains-loss cycles while request asserted
// - Count request-drop cycles while mains present
// - Store status and telemetry in listed order
// - Snapshot uses filtered values as already reported
// - Keep four older records behind the newest
// - Capture only while enable bit is one
module black_box_event_record import bbox_pkg::*; #(
   parameter longint unsigned MINUTE_CYCLES_P = MINUTE_CYCLES
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic mains_ok,
   input wire logic power_on_request_n,
   input wire logic bb_event,
   input wire telemetry_t telemetry,
   input wire logic clock_write_valid,
   input wire logic [RTC_W-1:0] clock_write_data,
   input wire logic config_write_valid,
   input wire logic [CFG_W-1:0] config_write_data,
   input wire logic read_req,
   input wire logic [SLOT_IDX_W-1:0] read_slot,
   input wire logic [BYTE_IDX_W-1:0] read_byte,
   output logic [BYTE_W-1:0] read_data,
   output logic read_valid,
   output logic [CFG_W-1:0] config_byte
);
   // ---------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------
   logic mains_s1;
   logic mains_s2;
   logic req_n_s1;
   logic req_n_s2;
   logic powered;

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         mains_s1 <= 1'b0;
         mains_s2 <= 1'b0;
         req_n_s1 <= 1'b1;
         req_n_s2 <= 1'b1;
      end else begin
         mains_s1 <= mains_ok;
         mains_s2 <= mains_s1;
         req_n_s1 <= power_on_request_n;
         req_n_s2 <= req_n_s1;
      end
   end

   assign powered = mains_s2 && !req_n_s2;

   // ---------------------------------------------
   // Volatile counters
   // ---------------------------------------------
   cycle_counts_t counts;

   power_cycle_tracker u_cycles (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .mains_ok(mains_s2),
      .power_request(!req_n_s2),
      .counts(counts)
   );

   logic [PRE_W-1:0] prescale;
   logic [PRE_W-1:0] next_prescale;
   logic [TIME_W-1:0] minutes;
   logic [TIME_W-1:0] next_minutes;
   logic minute_tick;

   assign minute_tick = powered && (prescale == PRE_W'(MINUTE_CYCLES_P - 1));

   // Saturates rather than wrapping: a wrapped count would look like a new unit
   always_comb begin
      next_prescale = prescale;
      next_minutes = minutes;
      if (powered) begin
         if (minute_tick) begin
            next_prescale = '0;
            if (minutes != TIME_MAX) begin
               next_minutes = minutes + 24'h000001;
            end
         end else begin
            next_prescale = prescale + 40'h0000000001;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         prescale <= '0;
         minutes <= '0;
      end else begin
         prescale <= next_prescale;
         minutes <= next_minutes;
      end
   end

   // ---------------------------------------------
   // Host clock value and configuration
   // ---------------------------------------------
   logic [RTC_W-1:0] rtc;
   logic [RTC_W-1:0] next_rtc;
   logic [CFG_W-1:0] next_config;

   always_comb begin
      next_rtc = rtc;
      next_config = config_byte;
      if (clock_write_valid) begin
         next_rtc = clock_write_data;
      end
      if (config_write_valid) begin
         next_config = config_write_data & CONFIG_MASK;
      end
   end

   // Enable lives in plain flops; it comes back enabled after every reset
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         rtc <= '0;
         config_byte <= CONFIG_RESET;
      end else begin
         rtc <= next_rtc;
         config_byte <= next_config;
      end
   end

   // ---------------------------------------------
   // Record slots
   // ---------------------------------------------
   record_t slots [SLOTS];
   record_t next_slots [SLOTS];
   record_t snapshot;
   logic capture;

   // Telemetry is taken as presented, already filtered upstream; short glitches may be absent
   assign snapshot = {telemetry, counts.request_cycles, counts.ac_cycles, rtc, minutes};
   assign capture = bb_event && config_byte[ENABLE_BIT];

   always_comb begin
      next_slots = slots;
      if (capture) begin
         for (int i = SLOTS - 1; i > 0; i--) begin
            next_slots[i] = slots[i-1];
         end
         next_slots[0] = snapshot;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < SLOTS; i++) begin
            slots[i] <= '0;
         end
      end else begin
         slots <= next_slots;
      end
   end

   // ---------------------------------------------
   // Read port
   // ---------------------------------------------
   logic [BYTE_W-1:0] next_read_data;

   // Out-of-range slot or byte reads return zero instead of aliasing
   always_comb begin
      next_read_data = read_data;
      if (read_req) begin
         if (int'(read_slot) < SLOTS && int'(read_byte) < REC_BYTES) begin
            next_read_data = slots[read_slot][read_byte];
         end else begin
            next_read_data = EMPTY_BYTE;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         read_data <= EMPTY_BYTE;
         read_valid <= 1'b0;
      end else begin
         read_data <= next_read_data;
         read_valid <= read_req;
      end
   end

   // ---------------------------------------------
   // Checks
   // ---------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   sequence armed_event;
      bb_event && config_byte[ENABLE_BIT];
   endsequence
   // A clock write, one quiet cycle, then an armed event
   sequence clock_then_event;
      clock_write_valid ##1 !clock_write_valid ##1 (bb_event && config_byte[ENABLE_BIT] && !clock_write_valid);
   endsequence

   a_newest_record: assert property (armed_event |=> slots[0] == $past(snapshot))
      else $error("newest slot does not hold the event snapshot");
   a_counter_copy: assert property (armed_event |=> slots[0][2:0] == $past(minutes)
      && {slots[0][10], slots[0][9], slots[0][8], slots[0][7]} == $past({counts.request_cycles, counts.ac_cycles}))
      else $error("counters not copied into record");
   a_minute_step: assert property (minute_tick && minutes != TIME_MAX |=> minutes == $past(minutes) + 24'h000001)
      else $error("on-time minute did not advance");
   a_clock_store: assert property (clock_then_event
      |=> {slots[0][6], slots[0][5], slots[0][4], slots[0][3]} == $past(clock_write_data, 3))
      else $error("stored clock value not recorded");
   a_status_order: assert property (armed_event |=> {slots[0][12], slots[0][11]} == $past(telemetry.status_word)
      && slots[0][13] == $past(telemetry.status_iout))
      else $error("status fields out of place");
   a_older_shift: assert property (armed_event |=> slots[1] == $past(slots[0])
      && slots[4] == $past(slots[3]))
      else $error("older records not shifted");
   a_disabled_hold: assert property (!config_byte[ENABLE_BIT] |=> $stable(slots[0]) && $stable(slots[4]))
      else $error("record changed while disabled");
   a_idle_hold: assert property (!bb_event [*2] |-> $stable(slots[0]))
      else $error("newest slot changed without an event");
   a_read_answer: assert property (read_req && read_slot == 3'h0 && read_byte == 6'h00 && !bb_event
      |=> read_valid && read_data == slots[0][0])
      else $error("read answer wrong");
endmodule : black_box_event_record
`default_nettype wire

// *** tb/host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----
// Host side of the management bus
// ----
module host_model import bbox_pkg::*; (
   input wire logic sys_clk,
   input wire logic [BYTE_W-1:0] read_data,
   input wire logic read_valid,
   output logic clock_write_valid,
   output logic [RTC_W-1:0] clock_write_data,
   output logic config_write_valid,
   output logic [CFG_W-1:0] config_write_data,
   output logic read_req,
   output logic [SLOT_IDX_W-1:0] read_slot,
   output logic [BYTE_IDX_W-1:0] read_byte
);
   initial begin
      clock_write_valid = 1'b0;
      clock_write_data = 32'h0;
      config_write_valid = 1'b0;
      config_write_data = 8'h0;
      read_req = 1'b0;
      read_slot = 3'h0;
      read_byte = 6'h0;
   end
   // Seconds since 1970, sent whole; data inverted after so stale values never pass
   task automatic put_clock(input logic [RTC_W-1:0] c);
      @(negedge sys_clk);
      clock_write_valid = 1'b1;
      clock_write_data = c;
      @(negedge sys_clk);
      clock_write_valid = 1'b0;
      clock_write_data = ~c;
   endtask : put_clock
   task automatic put_cfg(input logic [CFG_W-1:0] c);
      @(negedge sys_clk);
      config_write_valid = 1'b1;
      config_write_data = c;
      @(negedge sys_clk);
      config_write_valid = 1'b0;
      config_write_data = ~c;
   endtask : put_cfg
   // Answer stands one cycle, so it is taken at the next falling edge
   task automatic get(input logic [SLOT_IDX_W-1:0] s, input logic [BYTE_IDX_W-1:0] b,
                      output logic [BYTE_W-1:0] d, output logic v);
      @(negedge sys_clk);
      read_req = 1'b1;
      read_slot = s;
      read_byte = b;
      @(negedge sys_clk);
      read_req = 1'b0;
      read_slot = ~s;
      read_byte = ~b;
      v = read_valid;
      d = read_data;
   endtask : get
endmodule : host_model
`default_nettype wire

// *** tb/black_box_event_record_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin err_total++; \
   $display("unexpected %s expected %0h seen %0h", n, e, g); end end
// ----
// Bench
// ----
module black_box_event_record_bench import bbox_pkg::*;;
   typedef struct packed {logic [RTC_W-1:0] rtc; telemetry_t tel;} row_t;
   logic sys_clk, rst_b, mains_ok, power_on_request_n, bb_event;
   telemetry_t telemetry;
   logic cwv, cfv, rq, v;
   logic [RTC_W-1:0] cwd;
   logic [CFG_W-1:0] cfd, config_byte;
   logic [SLOT_IDX_W-1:0] rs;
   logic [BYTE_IDX_W-1:0] rb;
   logic [BYTE_W-1:0] read_data, d, e;
   logic read_valid;
   logic [BYTE_W-1:0] shadow [SLOTS][REC_BYTES];
   row_t rows [3];
   int err_total, checks, cyc;
   black_box_event_record #(.MINUTE_CYCLES_P(10)) dut_u (.sys_clk(sys_clk), .rst_b(rst_b),
      .mains_ok(mains_ok), .power_on_request_n(power_on_request_n), .bb_event(bb_event),
      .telemetry(telemetry), .clock_write_valid(cwv), .clock_write_data(cwd),
      .config_write_valid(cfv), .config_write_data(cfd), .read_req(rq), .read_slot(rs),
      .read_byte(rb), .read_data(read_data), .read_valid(read_valid), .config_byte(config_byte));
   host_model h_u (.sys_clk(sys_clk), .read_data(read_data), .read_valid(read_valid),
      .clock_write_valid(cwv), .clock_write_data(cwd), .config_write_valid(cfv),
      .config_write_data(cfd), .read_req(rq), .read_slot(rs), .read_byte(rb));
   always #5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         tally_and_finish();
      end
   end
   task automatic note(input logic [RTC_W-1:0] r, input telemetry_t t);
      for (int s = SLOTS - 1; s > 0; s--) shadow[s] = shadow[s-1];
      for (int k = 3; k < REC_BYTES; k++) begin
         if (k < 7) shadow[0][k] = r[(k-3)*8+:8];
         else if (k > 10) shadow[0][k] = t[(k-11)*8+:8];
      end
   endtask : note
   task automatic capture(input telemetry_t t, input logic [RTC_W-1:0] r, input logic en);
      @(negedge sys_clk);
      telemetry = t;
      bb_event = 1'b1;
      @(negedge sys_clk);
      bb_event = 1'b0;
      telemetry = ~t;
      if (en) note(r, t);
   endtask : capture
   // Counters and minutes are not predicted by the shadow, only host clock and telemetry
   task automatic check_slot(input int s);
      for (int k = 3; k < REC_BYTES; k++) begin
         if (k < 7 || k > 10) begin
            h_u.get(SLOT_IDX_W'(s), BYTE_IDX_W'(k), d, v);
            `CHK("record byte", shadow[s][k], d)
         end
      end
   endtask : check_slot
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : tally_and_finish
   initial begin
      sys_clk = 1'b0;
      rst_b = 1'b0;
      mains_ok = 1'b1;
      power_on_request_n = 1'b0;
      bb_event = 1'b0;
      telemetry = '0;
      shadow = '{default: 8'h00};
      rows[0] = {32'h6553F100, {9{24'hC35A01}}};
      rows[1] = {32'hFFFFFFFF, {3{72'h0F1E2D3C4B5A697887}}};
      rows[2] = {32'h00000001, {27{8'hFF}}};
      repeat (8) @(posedge sys_clk);
      @(negedge sys_clk);
      rst_b = 1'b1;
      `CHK("config", 8'h01, config_byte)
      h_u.get(3'h0, 6'h0, d, v);
      `CHK("read valid", 1'b1, v)
      `CHK("empty slot", 8'h00, d)
      $display("test reset done");
      h_u.put_clock(32'h60000000);
      repeat (48) @(negedge sys_clk);
      capture('0, 32'h60000000, 1'b1);
      for (int k = 0; k < 3; k++) begin
         h_u.get(3'h0, BYTE_IDX_W'(k), d, v);
         `CHK("minutes byte", (k == 0) ? 8'h05 : 8'h00, d)
      end
      $display("test minutes done");
      // Mains loss counts, request drop counts, mains loss while off does not
      mains_ok = 1'b0;
      repeat (5) @(negedge sys_clk);
      mains_ok = 1'b1;
      repeat (5) @(negedge sys_clk);
      power_on_request_n = 1'b1;
      repeat (5) @(negedge sys_clk);
      mains_ok = 1'b0;
      repeat (5) @(negedge sys_clk);
      mains_ok = 1'b1;
      repeat (5) @(negedge sys_clk);
      power_on_request_n = 1'b0;
      repeat (5) @(negedge sys_clk);
      capture('0, 32'h60000000, 1'b1);
      for (int k = 7; k < 11; k++) begin
         h_u.get(3'h0, BYTE_IDX_W'(k), d, v);
         // One mains cycle, one request cycle; the first turn-on after reset is not one
         e = (k == 7 || k == 9) ? 8'h01 : 8'h00;
         `CHK("cycle count byte", e, d)
      end
      check_slot(1);
      $display("test cycles done");
      for (int r = 0; r < 3; r++) begin
         h_u.put_clock(rows[r].rtc);
         capture(rows[r].tel, rows[r].rtc, 1'b1);
         check_slot(0);
         $display("test row %0d done", r);
      end
      // Back to back events: both must land, newest first
      @(negedge sys_clk);
      telemetry = rows[0].tel;
      bb_event = 1'b1;
      @(negedge sys_clk);
      telemetry = rows[1].tel;
      @(negedge sys_clk);
      bb_event = 1'b0;
      note(rows[2].rtc, rows[0].tel);
      note(rows[2].rtc, rows[1].tel);
      check_slot(0);
      check_slot(1);
      check_slot(4);
      $display("test back to back done");
      h_u.put_cfg(8'hFE);
      `CHK("config", 8'h00, config_byte)
      capture(rows[2].tel, rows[2].rtc, 1'b0);
      check_slot(0);
      h_u.put_cfg(8'hFF);
      `CHK("config", 8'h01, config_byte)
      h_u.get(3'h5, 6'h0, d, v);
      `CHK("bad slot", 8'h00, d)
      h_u.get(3'h0, 6'h26, d, v);
      `CHK("bad byte", 8'h00, d)
      $display("test disable and range done");
      // Mid-run reset: records cleared, recording enabled again
      h_u.put_cfg(8'h00);
      rst_b = 1'b0;
      repeat (2) @(negedge sys_clk);
      rst_b = 1'b1;
      `CHK("config after reset", 8'h01, config_byte)
      h_u.get(3'h4, 6'h0B, d, v);
      `CHK("slot after reset", 8'h00, d)
      $display("test mid-run reset done");
      tally_and_finish();
   end
endmodule : black_box_event_record_bench
`default_nettype wire
